// >>> rtl/swc_sleep_wakeup_control.sv
// Sleep entry, wake-up and vectoring control of the CPU core
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// R1: Enabled and flagged source is a wake condition even with global enable off.
// R2: Pending wake before sleep makes sleep a no-op; nothing changes.
// R3: Wake arriving during or after sleep: finish sleep, then wake immediately.
// R4: Completed sleep clears watchdog and postscaler, sets timeout, clears powerdown.
// R5: Powerdown status stays set when sleep degraded to a no-op.
// R6: Wait 1024 oscillator periods on wake, none in RC oscillator mode.
// R7: Global enable set vectors to 0004h; otherwise continue in program order.
// R8: Firmware should clear the watchdog before issuing sleep.
// R9: Instruction after sleep is prefetched and executed before any vectoring.
// R10: Wake-up occurs regardless of the global interrupt enable.
// R11: Vectoring inserts two dummy execute cycles.
module swc_sleep_wakeup_control #(
   parameter int NUM_SRC    = swc_pkg::SWC_NUM_SRC,
   parameter int OST_CYCLES = swc_pkg::SWC_OST_CYCLES
) (
   input  wire logic               core_clk,
   input  wire logic               srst,
   input  wire logic [NUM_SRC-1:0] irq_enable,
   input  wire logic [NUM_SRC-1:0] irq_flag,
   input  wire logic               global_irq_enable,
   input  wire logic               rc_osc_mode,
   input  wire logic               sleep_instr,
   input  wire logic               watchdog_clear_instr,
   input  wire logic               watchdog_timeout,
   output      logic               watchdog_clear,
   output      swc_pkg::swc_status_s status,
   output      swc_pkg::swc_seq_s    seq,
   output      logic               asleep
);
   import swc_pkg::*;

   localparam int CW = $clog2(OST_CYCLES + 1);

   swc_state_e         state_q, state_d;
   logic [CW-1:0]      ost_cnt_q;
   logic               dummy_cnt_q;
   logic               gie_q;
   swc_status_s        status_d;
   swc_seq_s           seq_d;
   logic               wdt_clr_d;

   ////////////////////////////////////////////////////////////////////////////
   // Wake decode ignores the global enable on purpose
   wire wake_pending = |(irq_enable & irq_flag);  // [R1] [R10]
   // A degraded sleep needs no wire of its own: status simply holds
   wire sleep_full   = sleep_instr && (state_q == SWC_RUN) && !wake_pending;  // [R2]
   wire ost_done     = (ost_cnt_q == CW'(OST_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      case (state_q)
         SWC_RUN: begin
            if (sleep_full) begin
               state_d = SWC_SLEEP;
            end
         end
         SWC_SLEEP: begin
            // Watchdog time-out also wakes, in-line
            if (wake_pending || watchdog_timeout) begin  // [R3]
               state_d = rc_osc_mode ? SWC_NEXT : SWC_OST;  // [R6]
            end
         end
         SWC_OST: begin
            if (ost_done) begin  // [R6]
               state_d = SWC_NEXT;
            end
         end
         SWC_NEXT: begin
            state_d = (gie_q && wake_pending) ? SWC_DUMMY : SWC_RUN;  // [R7] [R9]
         end
         SWC_DUMMY: begin
            if (dummy_cnt_q) begin  // [R11]
               state_d = SWC_VEC;
            end
         end
         SWC_VEC: state_d = SWC_RUN;
         default: state_d = SWC_RUN;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      status_d = status;
      wdt_clr_d = watchdog_clear_instr;
      if (sleep_full) begin
         status_d.timeout_status   = 1'b1;  // [R4]
         status_d.powerdown_status = 1'b0;  // [R4]
         wdt_clr_d                 = 1'b1;  // [R4]
      end else if (watchdog_clear_instr) begin
         status_d.timeout_status   = 1'b1;
         status_d.powerdown_status = 1'b1;  // [R5]
      end
      if (watchdog_timeout) begin
         status_d.timeout_status = 1'b0;
      end
      seq_d             = '0;
      seq_d.osc_run     = (state_d != SWC_SLEEP) && (state_d != SWC_OST);
      seq_d.exec_stall  = (state_d == SWC_SLEEP) || (state_d == SWC_OST);
      seq_d.exec_next   = (state_d == SWC_NEXT);  // [R9]
      seq_d.dummy_cycle = (state_d == SWC_DUMMY);  // [R11]
      seq_d.load_vector = (state_d == SWC_DUMMY) && !dummy_cnt_q && (state_q == SWC_NEXT);
      seq_d.vector_addr = SWC_IRQ_VECTOR;  // [R7]
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q        <= SWC_RUN;
         ost_cnt_q      <= '0;
         dummy_cnt_q    <= 1'b0;
         gie_q          <= 1'b0;
         status         <= '{timeout_status: SWC_TO_RESET, powerdown_status: SWC_PD_RESET};
         seq            <= '0;
         watchdog_clear <= 1'b0;
         asleep         <= 1'b0;
      end else begin
         state_q        <= state_d;
         ost_cnt_q      <= (state_q == SWC_OST) ? ost_cnt_q + CW'(1) : '0;
         dummy_cnt_q    <= (state_q == SWC_DUMMY) ? ~dummy_cnt_q : 1'b0;
         gie_q          <= global_irq_enable;
         status         <= status_d;  // [R2] [R5]
         seq            <= seq_d;
         watchdog_clear <= wdt_clr_d;  // [R8]
         asleep         <= (state_d == SWC_SLEEP);
      end
   end
endmodule

// >>> rtl/swc_pkg.sv
// Package of constants and types for the sleep and wake-up controller
package swc_pkg;
   localparam logic [12:0] SWC_IRQ_VECTOR   = 13'h0004;
   localparam int          SWC_OST_TOSC     = 1024;
   localparam int          SWC_TOSC_PER_CYC = 1;
   localparam int          SWC_OST_CYCLES   = SWC_OST_TOSC * SWC_TOSC_PER_CYC;
   localparam int          SWC_DUMMY_CYCLES = 2;
   localparam logic        SWC_TO_RESET     = 1'b1;
   localparam logic        SWC_PD_RESET     = 1'b1;
   localparam int          SWC_NUM_SRC      = 4;

   typedef enum logic [5:0] {
      SWC_RUN   = 6'h01,
      SWC_SLEEP = 6'h02,
      SWC_OST   = 6'h04,
      SWC_NEXT  = 6'h08,
      SWC_DUMMY = 6'h10,
      SWC_VEC   = 6'h20
   } swc_state_e;

   // Status seen by firmware
   typedef struct packed {
      logic timeout_status;
      logic powerdown_status;
   } swc_status_s;

   // Commands to the instruction sequencer
   typedef struct packed {
      logic        osc_run;
      logic        exec_stall;
      logic        exec_next;
      logic        dummy_cycle;
      logic        load_vector;
      logic [12:0] vector_addr;
   } swc_seq_s;
endpackage

// >>> verification/swc_chk.sv
// Checker of sleep entry and wake-up timing
`timescale 1ns/1ps
module swc_chk
   import swc_pkg::*;
#(parameter int NUM_SRC = 4, parameter int OST_CYCLES = 8) (
   input wire logic                 core_clk,
   input wire logic                 srst,
   input wire logic [NUM_SRC-1:0]   irq_enable,
   input wire logic [NUM_SRC-1:0]   irq_flag,
   input wire logic                 global_irq_enable,
   input wire logic                 rc_osc_mode,
   input wire logic                 sleep_instr,
   input wire logic                 watchdog_clear,
   input wire swc_pkg::swc_status_s status,
   input wire swc_pkg::swc_seq_s    seq,
   input wire logic                 asleep
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   localparam int LO = OST_CYCLES - 1;
   localparam int HI = OST_CYCLES + 1;
   wire pend = |(irq_enable & irq_flag);
   wire run = !asleep && !seq.exec_stall;
   a_noop_sleep: assert property (sleep_instr && run && pend |=> !asleep && $stable(status))
      else $error("sleep not a no-op");
   a_full_sleep: assert property (sleep_instr && run && !pend |=> asleep && watchdog_clear
      && status == 2'b10) else $error("sleep entry wrong");
   a_wake_now: assert property (asleep && pend |=> !asleep) else $error("no wake");
   a_ost_wait: assert property ($fell(asleep) && !rc_osc_mode |-> ##[LO:HI] seq.exec_next)
      else $error("start-up wait wrong");
   a_rc_nowait: assert property ($fell(asleep) && rc_osc_mode |-> ##[0:2] seq.exec_next)
      else $error("rc wake slow");
   a_vec_entry: assert property (seq.exec_next && global_irq_enable && pend |=> seq.dummy_cycle
      && seq.load_vector ##1 seq.dummy_cycle && !seq.load_vector) else $error("no vector");
   a_inline_run: assert property (seq.exec_next && !global_irq_enable |=> !seq.dummy_cycle)
      else $error("vector with enable off");
   a_vec_addr: assert property (seq.load_vector |-> seq.vector_addr == SWC_IRQ_VECTOR)
      else $error("vector address wrong");
endmodule
bind swc_sleep_wakeup_control swc_chk #(.NUM_SRC(NUM_SRC), .OST_CYCLES(OST_CYCLES)) u_chk (.*);

// >>> verification/swc_irq_src.sv
// Model of the on-chip interrupt sources
`timescale 1ns/1ps
module swc_irq_src (
   input  wire logic       core_clk,
   input  wire logic [3:0] set,
   input  wire logic [3:0] clr,
   output      logic [3:0] flag
);
   // Flag holds until firmware clears it
   always_ff @(posedge core_clk) begin
      flag <= (flag | set) & ~clr;
   end
endmodule

// >>> verification/tb_swc_sleep_wakeup_control.sv
// Self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ps
module tb_swc_sleep_wakeup_control;
   import swc_pkg::*;
   logic core_clk = '0, srst = 1'h1, global_irq_enable = '0, rc_osc_mode = '0;
   logic sleep_instr = '0, watchdog_clear_instr = '0, watchdog_timeout = '0;
   logic watchdog_clear, asleep, nxt_q = '0;
   logic [3:0] irq_enable = '0, irq_flag, set = '0, clr = 4'hf;
   swc_status_s status;
   swc_seq_s    seq;
   logic [2:0]  exp_q[$];
   int          n_fail = 0, checks_done = 0, cyc = 0, k;
   swc_sleep_wakeup_control #(.OST_CYCLES(8)) dut_u (.*);
   swc_irq_src src_u (.core_clk(core_clk), .set(set), .clr(clr), .flag(irq_flag));
   initial forever #2 core_clk = ~core_clk;
   task automatic cy(int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk(string nm, logic [2:0] e, logic [2:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Result appears the cycle after the resume pulse
   always @(posedge core_clk) begin
      cyc++;
      if (cyc > 4000) begin
         n_fail++;
         end_of_test;
      end
      if (nxt_q) chk("wake", exp_q.pop_front(), {status, seq.dummy_cycle});
      nxt_q <= seq.exec_next;
   end
   initial begin
      void'($urandom(32'hb9b33180));
      cy(16);
      srst <= '0;
      clr <= '0;
      for (int i = 0; i < 5; i++) begin
         k = $urandom % 4;
         global_irq_enable <= i[0];
         rc_osc_mode <= i[1];
         irq_enable <= (4'h1 << k) | 4'($urandom);
         watchdog_clear_instr <= 1'h1;
         cy(1);
         watchdog_clear_instr <= '0;
         if (i == 4) set <= 4'h1 << k;
         cy(2);
         sleep_instr <= 1'h1;
         cy(1);
         sleep_instr <= '0;
         if (i < 4) begin
            exp_q.push_back({2'b10, i[0]});
            cy(3);
            set <= 4'h1 << k;
            cy(1);
            set <= '0;
            while (!nxt_q) cy(1);
            cy(4);
         end else begin
            set <= '0;
            cy(2);
            chk("noop", 3'h6, {status, asleep});
         end
         clr <= 4'hf;
         cy(1);
         clr <= '0;
      end
      cy(5);
      end_of_test;
   end
endmodule
